// ==== inc/agc_cs_pkg.sv ====
package agc_cs_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_GOAL = 6'h1b;
  localparam logic [5:0] OFS_CS = 6'h1c;
  localparam logic [5:0] OFS_TIMING = 6'h1d;
  localparam logic [2:0] RST_GOAL = 3'h3;
  localparam logic [6:0] RST_CS = 7'h40;
  localparam logic [7:0] RST_TIMING = 8'h91;
  localparam logic [2:0] RST_AVG_LOG2 = 3'h4;
  localparam logic [4:0] RST_BOUND = 5'h08;
  localparam int CS_PRIO_BIT = 6;
  localparam int CS_REL_LSB = 4;
  localparam int CS_ABS_LSB = 0;
  localparam int TM_HYST_LSB = 6;
  localparam int TM_WAIT_LSB = 4;
  localparam int TM_HOLD_LSB = 2;
  localparam int TM_FLEN_LSB = 0;
  localparam logic [3:0] CS_ABS_OFF = 4'h8;
  localparam int WAIT_SHIFT = 3;
  localparam int BOUND_SHIFT = 2;
  localparam logic [2:0] AVG_LOG2_BASE = 3'h3;
  localparam logic [2:0] OOK_AVG_LOG2 = 3'h3;

  typedef enum logic [1:0] {
    HOLD_NONE = 2'h0, HOLD_ON_SYNC = 2'h1, HOLD_ANALOG = 2'h2, HOLD_ALL = 2'h3
  } hold_policy_t;
  typedef enum logic [2:0] {
    LP_TRACK = 3'b001, LP_STEP = 3'b010, LP_HOLD = 3'b100
  } loop_state_t;
  typedef enum logic [1:0] {
    AV_DISCARD = 2'b01, AV_ACCUM = 2'b10
  } avg_state_t;

  function automatic logic [7:0] goal_db(input logic [2:0] code);
    logic [7:0] t [8];
    t = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
    return t[code];
  endfunction
  function automatic logic [7:0] rel_step_db(input logic [1:0] code);
    logic [7:0] t [4];
    t = '{8'h00, 8'h06, 8'h0a, 8'h0e};
    return t[code];
  endfunction
  // {lower, upper} window in dB around the goal
  function automatic logic [7:0] deadzone(input logic [1:0] code);
    logic [7:0] t [4];
    t = '{8'h22, 8'h24, 8'h36, 8'h4a};
    return t[code];
  endfunction
endpackage

// ==== inc/agc_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface agc_link_if;
  logic sample_valid;
  logic [7:0] sample_db;
  logic restart;
  logic [5:0] discard_n;
  logic [2:0] avg_log2;
  logic [7:0] avg_db;
  logic avg_valid;
  logic [7:0] rssi_db;
  logic rssi_valid;
  logic [1:0] rel_code;
  logic [3:0] abs_code;
  logic [7:0] goal_db;
  logic cs;
  modport loop(output sample_valid, sample_db, restart, discard_n, avg_log2,
    rssi_db, rssi_valid, rel_code, abs_code, goal_db,
    input avg_db, avg_valid, cs);
  modport avg(input sample_valid, sample_db, restart, discard_n, avg_log2,
    output avg_db, avg_valid);
  modport det(input rssi_db, rssi_valid, rel_code, abs_code, goal_db,
    output cs);
endinterface
`default_nettype wire

// ==== logic/amp_averager.sv ====
`timescale 1ns/1ns
`default_nettype none
module amp_averager (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // loop side
  agc_link_if.avg lk
);
  import agc_cs_pkg::*;
  avg_state_t st_r, st_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic [13:0] sum_r, sum_nxt;
  logic [7:0] avg_r, avg_nxt;
  logic vld_r, vld_nxt;
  logic [13:0] acc;
  logic [6:0] last_acc;
  logic [6:0] last_disc;

  // discard window, then block averages until the next restart
  always_comb begin
    acc = sum_r + {6'h00, lk.sample_db};
    last_acc = 7'((8'h01 << lk.avg_log2) - 8'h01);
    last_disc = {1'b0, lk.discard_n - 6'h01};
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sum_nxt = sum_r;
    avg_nxt = avg_r;
    vld_nxt = 1'b0;
    if (lk.restart) begin
      st_nxt = AV_DISCARD;
      cnt_nxt = 7'h00;
      sum_nxt = 14'h0000;
    end else if (lk.sample_valid) begin
      unique case (st_r)
        AV_DISCARD: begin
          // >= guards against the wait field shrinking mid-window
          if (cnt_r >= last_disc) begin
            st_nxt = AV_ACCUM;
            cnt_nxt = 7'h00;
          end else begin
            cnt_nxt = cnt_r + 7'h01;
          end
        end
        AV_ACCUM: begin
          if (cnt_r >= last_acc) begin
            avg_nxt = 8'(acc >> lk.avg_log2);
            vld_nxt = 1'b1;
            sum_nxt = 14'h0000;
            cnt_nxt = 7'h00;
          end else begin
            sum_nxt = acc;
            cnt_nxt = cnt_r + 7'h01;
          end
        end
        default: st_nxt = AV_DISCARD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= AV_DISCARD;
      cnt_r <= 7'h00;
      sum_r <= 14'h0000;
      avg_r <= 8'h00;
      vld_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
      avg_r <= avg_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign lk.avg_db = avg_r;
  assign lk.avg_valid = vld_r;

  property p_discard_end;
    @(posedge clk) disable iff (!reset_n)
    (st_r == AV_DISCARD && !lk.restart && lk.sample_valid
      && cnt_r == last_disc) |=> (st_r == AV_ACCUM && sum_r == 14'h0000);
  endproperty
  a_discard_end: assert property (p_discard_end)
    else $error("discard window did not end on its last sample");

  property p_no_avg_in_discard;
    @(posedge clk) disable iff (!reset_n)
    lk.restart |=> !lk.avg_valid ##1 !lk.avg_valid [*7];
  endproperty
  a_no_avg_in_discard: assert property (p_no_avg_in_discard)
    else $error("average produced inside discard window");
endmodule
`default_nettype wire

// ==== logic/cs_detect.sv ====
`timescale 1ns/1ns
`default_nettype none
module cs_detect (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // loop side
  agc_link_if.det lk
);
  import agc_cs_pkg::*;
  logic cs_r, cs_nxt;
  logic [7:0] base_r, base_nxt;
  logic base_ok_r, base_ok_nxt;
  logic signed [9:0] thr;
  logic abs_en, abs_hit, rel_hit;

  // rssi is referred to full gain, so compare straight to goal plus offset
  always_comb begin
    abs_en = (lk.abs_code != CS_ABS_OFF);
    thr = $signed({2'b00, lk.goal_db})
      + 10'(signed'(lk.abs_code));
    abs_hit = abs_en && ($signed({2'b00, lk.rssi_db}) >= thr);
    rel_hit = (lk.rel_code != 2'h0) && base_ok_r
      && ({1'b0, lk.rssi_db}
        >= {1'b0, base_r} + {1'b0, rel_step_db(lk.rel_code)});
    cs_nxt = cs_r;
    base_nxt = base_r;
    base_ok_nxt = base_ok_r;
    if (lk.rssi_valid) begin
      cs_nxt = abs_hit || rel_hit;
      // baseline follows the floor only while no carrier is seen
      if (!cs_nxt) begin
        base_nxt = lk.rssi_db;
        base_ok_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_r <= 1'b0;
      base_r <= 8'h00;
      base_ok_r <= 1'b0;
    end else begin
      cs_r <= cs_nxt;
      base_r <= base_nxt;
      base_ok_r <= base_ok_nxt;
    end
  end

  assign lk.cs = cs_r;

  property p_abs_off;
    @(posedge clk) disable iff (!reset_n)
    (lk.rssi_valid && lk.abs_code == 4'h8 && lk.rel_code == 2'h0)
      |=> !lk.cs;
  endproperty
  a_abs_off: assert property (p_abs_off)
    else $error("carrier sense raised with both criteria off");

  property p_abs_hit;
    @(posedge clk) disable iff (!reset_n)
    (lk.rssi_valid && lk.abs_code != 4'h8
      && $signed({2'b00, lk.rssi_db}) >= $signed({2'b00, lk.goal_db})
        + 10'(signed'(lk.abs_code))) |=> lk.cs;
  endproperty
  a_abs_hit: assert property (p_abs_hit)
    else $error("absolute threshold met but carrier sense low");
endmodule
`default_nettype wire

// ==== logic/agc_cs_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module agc_cs_ctrl #(
  parameter int GAIN_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [agc_cs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic [7:0] reg_rdata,
  // receive datapath
  input wire logic sample_valid,
  input wire logic [7:0] sample_db,
  input wire logic rssi_valid,
  input wire logic [7:0] rssi_db,
  input wire logic sync_found,
  input wire logic rx_start,
  input wire logic ook_mode,
  // manual gain values
  input wire logic [GAIN_W-1:0] manual_stage1,
  input wire logic [GAIN_W-1:0] manual_stage2,
  input wire logic [GAIN_W-1:0] manual_digital,
  // gain settings
  output logic [GAIN_W-1:0] front_amp_stage1,
  output logic [GAIN_W-1:0] front_amp_stage2,
  output logic [GAIN_W-1:0] digital_gain,
  // detector and demodulator settings
  output logic carrier_sense,
  output logic [4:0] ook_boundary_db,
  output logic [6:0] avg_length
);
  import agc_cs_pkg::*;
  localparam logic [GAIN_W-1:0] GMAX = '1;
  localparam logic [GAIN_W-1:0] GONE = GAIN_W'(1);

  agc_link_if lk ();

  // register state
  logic [2:0] goal_r, goal_nxt;
  logic [6:0] cs_ctrl_r, cs_ctrl_nxt;
  logic [7:0] timing_r, timing_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  // decoded fields
  logic stage_reduce_order;
  logic [1:0] cs_relative_step;
  logic [3:0] cs_absolute_offset;
  logic [2:0] amplitude_goal;
  logic [1:0] deadzone_select;
  logic [1:0] wait_sel;
  hold_policy_t gain_hold_policy;
  logic [1:0] flen_sel;

  // register writes land on the next edge; reads are registered
  always_comb begin
    goal_nxt = goal_r;
    cs_ctrl_nxt = cs_ctrl_r;
    timing_nxt = timing_r;
    if (reg_we) begin
      unique case (reg_addr)
        OFS_GOAL: goal_nxt = reg_wdata[2:0];
        OFS_CS: cs_ctrl_nxt = reg_wdata[6:0];
        OFS_TIMING: timing_nxt = reg_wdata;
        default: ;
      endcase
    end
    unique case (reg_addr)
      OFS_GOAL: rdata_nxt = {5'h00, goal_r};
      OFS_CS: rdata_nxt = {1'b0, cs_ctrl_r}; // top bit reads zero
      OFS_TIMING: rdata_nxt = timing_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      goal_r <= RST_GOAL;
      cs_ctrl_r <= RST_CS;
      timing_r <= RST_TIMING;
      rdata_r <= 8'h00;
    end else begin
      goal_r <= goal_nxt;
      cs_ctrl_r <= cs_ctrl_nxt;
      timing_r <= timing_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // field decode
  assign stage_reduce_order = cs_ctrl_r[CS_PRIO_BIT];
  assign cs_relative_step = cs_ctrl_r[CS_REL_LSB +: 2];
  assign cs_absolute_offset = cs_ctrl_r[CS_ABS_LSB +: 4];
  assign amplitude_goal = goal_r;
  assign deadzone_select = timing_r[TM_HYST_LSB +: 2];
  assign wait_sel = timing_r[TM_WAIT_LSB +: 2];
  assign gain_hold_policy = hold_policy_t'(timing_r[TM_HOLD_LSB +: 2]);
  assign flen_sel = timing_r[TM_FLEN_LSB +: 2];
  assign reg_rdata = rdata_r;

  // loop state
  loop_state_t st_r, st_nxt;
  logic [GAIN_W-1:0] s1_r, s1_nxt, s2_r, s2_nxt, dg_r, dg_nxt;
  logic sync_hold_r, sync_hold_nxt;
  logic [2:0] avg_log2_r, avg_log2_nxt;
  logic [4:0] bound_r, bound_nxt;
  logic hold_all, analog_frz, too_high, too_low;
  logic signed [9:0] dev;
  logic [7:0] dz;

  // averager and detector hookup
  assign lk.sample_valid = sample_valid;
  assign lk.sample_db = sample_db;
  assign lk.rssi_valid = rssi_valid;
  assign lk.rssi_db = rssi_db;
  assign lk.rel_code = cs_relative_step;
  assign lk.abs_code = cs_absolute_offset;
  assign lk.goal_db = goal_db(amplitude_goal);
  assign lk.avg_log2 = avg_log2_r;
  assign lk.discard_n =
    6'(({4'h0, wait_sel} + 6'h01) << WAIT_SHIFT);
  // a fresh window after every gain step and every new reception
  assign lk.restart = (st_r == LP_STEP) || rx_start;
  assign carrier_sense = lk.cs;

  amp_averager u_avg (
    .clk(clk),
    .reset_n(reset_n),
    .lk(lk.avg)
  );

  cs_detect u_cs (
    .clk(clk),
    .reset_n(reset_n),
    .lk(lk.det)
  );

  // gain stepping, priority order and hold policies
  always_comb begin
    hold_all = (gain_hold_policy == HOLD_ALL)
      || (gain_hold_policy == HOLD_ON_SYNC && sync_hold_r);
    analog_frz = (gain_hold_policy == HOLD_ANALOG);
    dz = deadzone(deadzone_select);
    dev = $signed({2'b00, lk.avg_db}) - $signed({2'b00, lk.goal_db});
    too_high = dev > $signed({6'h00, dz[3:0]});
    too_low = dev < -$signed({6'h00, dz[7:4]});
    st_nxt = st_r;
    s1_nxt = s1_r;
    s2_nxt = s2_r;
    dg_nxt = dg_r;
    unique case (st_r)
      LP_TRACK: begin
        if (hold_all) begin
          st_nxt = LP_HOLD;
        end else if (lk.avg_valid && (too_high || too_low)) begin
          st_nxt = LP_STEP;
          if (too_high) begin
            if (!analog_frz && stage_reduce_order && s1_r != '0) begin
              s1_nxt = s1_r - GONE;
            end else if (!analog_frz && s2_r != '0) begin
              s2_nxt = s2_r - GONE;
            end else if (!analog_frz && s1_r != '0) begin
              s1_nxt = s1_r - GONE;
            end else if (dg_r != '0) begin
              dg_nxt = dg_r - GONE;
            end
          end else begin
            // raise in the reverse of the reduce order
            if (dg_r != GMAX) begin
              dg_nxt = dg_r + GONE;
            end else if (!analog_frz && stage_reduce_order
              && s2_r != GMAX) begin
              s2_nxt = s2_r + GONE;
            end else if (!analog_frz && s1_r != GMAX) begin
              s1_nxt = s1_r + GONE;
            end else if (!analog_frz && s2_r != GMAX) begin
              s2_nxt = s2_r + GONE;
            end
          end
        end
      end
      LP_STEP: st_nxt = hold_all ? LP_HOLD : LP_TRACK;
      LP_HOLD: begin
        if (gain_hold_policy == HOLD_ALL) begin
          s1_nxt = manual_stage1;
          s2_nxt = manual_stage2;
          dg_nxt = manual_digital;
        end
        if (!hold_all) begin
          st_nxt = LP_STEP;
        end
      end
      default: st_nxt = LP_TRACK;
    endcase
    // a sync event in the clearing cycle still wins
    if (gain_hold_policy == HOLD_ON_SYNC && sync_found) begin
      sync_hold_nxt = 1'b1;
    end else if (rx_start) begin
      sync_hold_nxt = 1'b0;
    end else begin
      sync_hold_nxt = sync_hold_r;
    end
    // ook reception uses a fixed short average
    avg_log2_nxt = ook_mode ? OOK_AVG_LOG2
      : AVG_LOG2_BASE + {1'b0, flen_sel};
    bound_nxt = 5'(({3'h0, flen_sel} + 5'h01) << BOUND_SHIFT);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= LP_TRACK;
      s1_r <= '1;
      s2_r <= '1;
      dg_r <= '1;
      sync_hold_r <= 1'b0;
      avg_log2_r <= RST_AVG_LOG2;
      bound_r <= RST_BOUND;
    end else begin
      st_r <= st_nxt;
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      dg_r <= dg_nxt;
      sync_hold_r <= sync_hold_nxt;
      avg_log2_r <= avg_log2_nxt;
      bound_r <= bound_nxt;
    end
  end

  assign front_amp_stage1 = s1_r;
  assign front_amp_stage2 = s2_r;
  assign digital_gain = dg_r;
  assign ook_boundary_db = bound_r;
  assign avg_length = 7'(8'h01 << avg_log2_r);

  // reduce decision taken in this cycle while the analogue stages are not frozen, for the checks below
  logic cut_now;
  assign cut_now = st_r == LP_TRACK && !hold_all && lk.avg_valid
    && too_high && !analog_frz;

  property p_prio_stage1;
    @(posedge clk) disable iff (!reset_n)
    (cut_now && stage_reduce_order && s1_r != '0)
      |=> (s1_r == $past(s1_r) - GONE) && $stable(s2_r);
  endproperty
  a_prio_stage1: assert property (p_prio_stage1)
    else $error("stage one not lowered first");

  property p_prio_stage2;
    @(posedge clk) disable iff (!reset_n)
    (cut_now && !stage_reduce_order && s2_r != '0)
      |=> (s2_r == $past(s2_r) - GONE) && $stable(s1_r);
  endproperty
  a_prio_stage2: assert property (p_prio_stage2)
    else $error("stage two not taken to minimum first");

  property p_sync_hold;
    @(posedge clk) disable iff (!reset_n)
    (gain_hold_policy == HOLD_ON_SYNC && sync_hold_r)
      |=> $stable(s1_r) && $stable(s2_r) && $stable(dg_r);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("gain moved after sync word");

  property p_analog_hold;
    @(posedge clk) disable iff (!reset_n)
    (gain_hold_policy == HOLD_ANALOG)
      |=> $stable(s1_r) && $stable(s2_r);
  endproperty
  a_analog_hold: assert property (p_analog_hold)
    else $error("analogue gain moved while held");

  property p_manual;
    @(posedge clk) disable iff (!reset_n)
    (st_r == LP_HOLD && gain_hold_policy == HOLD_ALL)
      |=> s1_r == $past(manual_stage1) && dg_r == $past(manual_digital);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual gain not applied");

  property p_step_restart;
    @(posedge clk) disable iff (!reset_n)
    (st_r == LP_TRACK && lk.avg_valid && !hold_all
      && (too_high || too_low)) |=> lk.restart ##1 !lk.avg_valid;
  endproperty
  a_step_restart: assert property (p_step_restart)
    else $error("gain step did not restart averaging");
endmodule
`default_nettype wire

// ==== testbench/agc_cs_ctrl_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module agc_cs_ctrl_tb;
  import agc_cs_pkg::*;
  typedef struct {int what; logic [7:0] exp;} note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic [7:0] reg_rdata;
  logic sample_valid = 1'b0;
  logic [7:0] sample_db = 8'h00;
  logic rssi_valid = 1'b0;
  logic [7:0] rssi_db = 8'h00;
  logic sync_found = 1'b0;
  logic rx_start = 1'b0;
  logic ook_mode = 1'b0;
  // match the reset gains, so a random full-hold write cannot move them
  logic [2:0] man1 = 3'h7, man2 = 3'h7, mand = 3'h7;
  logic [2:0] st1, st2, dgain;
  logic carrier_sense;
  logic [4:0] ook_boundary_db;
  logic [6:0] avg_length;
  int n_fail = 0;
  int comparisons = 0;
  int seed = 16113;
  logic [2:0] e1 = 3'h7, e2 = 3'h7, ed = 3'h7;
  logic prio = 1'b1;
  note_t notes[$];
  event due;
  string nm[7] = '{"reg_rdata", "front_amp_stage1", "front_amp_stage2",
    "digital_gain", "carrier_sense", "ook_boundary_db", "avg_length"};

  agc_cs_ctrl #(.GAIN_W(3)) u_dut (
    .clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_db(sample_db),
    .rssi_valid(rssi_valid), .rssi_db(rssi_db),
    .sync_found(sync_found), .rx_start(rx_start), .ook_mode(ook_mode),
    .manual_stage1(man1), .manual_stage2(man2), .manual_digital(mand),
    .front_amp_stage1(st1), .front_amp_stage2(st2), .digital_gain(dgain),
    .carrier_sense(carrier_sense), .ook_boundary_db(ook_boundary_db),
    .avg_length(avg_length)
  );

  // 100 mhz clock
  always #5 clk = ~clk;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [7:0] obs(input int w);
    case (w)
      0: return reg_rdata;
      1: return {5'h0, st1};
      2: return {5'h0, st2};
      3: return {5'h0, dgain};
      4: return {7'h0, carrier_sense};
      5: return {3'h0, ook_boundary_db};
      default: return {1'b0, avg_length};
    endcase
  endfunction

  // oldest note first, once the driver says results have landed
  initial begin
    note_t nt;
    forever begin
      @(due);
      while (notes.size() > 0) begin
        nt = notes.pop_front();
        check(nm[nt.what], obs(nt.what), nt.exp);
      end
    end
  end

  task automatic note(input int what, input logic [7:0] exp);
    notes.push_back('{what, exp});
  endtask

  // trailing tick keeps two writes from toggling the strobe in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    tick();
    reg_we = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick();
    note(0, exp);
    ->due;
  endtask

  task automatic rssi(input logic [7:0] v, input logic exp);
    rssi_db = v;
    rssi_valid = 1'b1;
    tick();
    rssi_valid = 1'b0;
    note(4, {7'h0, exp});
    ->due;
    tick();
  endtask

  task automatic restart();
    rx_start = 1'b1;
    tick();
    rx_start = 1'b0;
    tick(2);
  endtask

  task automatic feed(input int n, input logic [7:0] v);
    sample_db = v;
    sample_valid = 1'b1;
    tick(n);
    sample_valid = 1'b0;
    tick(4);
  endtask

  task automatic chk_gains();
    note(1, {5'h0, e1});
    note(2, {5'h0, e2});
    note(3, {5'h0, ed});
    ->due;
  endtask

  // bench view of which stage gives way next; k=2 digital only, k=3 raise
  task automatic model_step(input int k);
    if (k == 3) begin
      if (ed < 7) ed++;
      else if (prio && e2 < 7) e2++;
      else if (e1 < 7) e1++;
      else if (e2 < 7) e2++;
    end else if (k == 2) begin
      if (ed > 0) ed--;
    end else if (prio && e1 > 0) e1--;
    else if (e2 > 0) e2--;
    else if (e1 > 0) e1--;
    else if (ed > 0) ed--;
  endtask

  task automatic episode(input int n, input logic [7:0] v, input int k);
    restart();
    feed(n, v);
    if (k != 0) model_step(k);
    chk_gains();
  endtask

  // stalls past any sane run length count as a failure
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] thr;
    logic [7:0] gt[8] = '{8'd24, 8'd27, 8'd30, 8'd33, 8'd36, 8'd38, 8'd40,
      8'd42};
    logic [7:0] rs[4] = '{8'd0, 8'd6, 8'd10, 8'd14};
    logic [7:0] up[4] = '{8'd2, 8'd4, 8'd6, 8'd10};
    logic [7:0] lw[4] = '{8'd2, 8'd2, 8'd3, 8'd4};
    logic [7:0] msk[3] = '{8'h07, 8'h7f, 8'hff};
    int off;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd(OFS_GOAL, 8'h03);
    rd(OFS_CS, 8'h40);
    rd(OFS_TIMING, 8'h91);
    chk_gains();
    note(4, 8'h00);
    note(5, 8'd8);
    note(6, 8'd16);
    ->due;
    // random write and read back, unused bits read zero
    for (int i = 0; i < 9; i++) begin
      d = 8'($random(seed));
      wr(OFS_GOAL + 6'(i % 3), d);
      rd(OFS_GOAL + 6'(i % 3), d & msk[i % 3]);
    end
    wr(6'h3f, 8'hff);
    rd(6'h3f, 8'h00);
    rd(OFS_TIMING, d);
    // length field in both keying kinds
    for (int l = 0; l < 4; l++) begin
      wr(OFS_TIMING, {6'h24, 2'(l)});
      restart();
      note(5, 8'(4 * (l + 1)));
      note(6, 8'(8 << l));
      ->due;
    end
    ook_mode = 1'b1;
    restart();
    note(6, 8'd8);
    ->due;
    ook_mode = 1'b0;
    // absolute threshold for every goal code
    for (int g = 0; g < 8; g++) begin
      off = $random(seed) % 8;
      wr(OFS_GOAL, 8'(g));
      wr(OFS_CS, {4'h4, 4'(off)});
      thr = gt[g] + 8'(off);
      rssi(thr, 1'b1);
      rssi(thr - 8'h01, 1'b0);
    end
    wr(OFS_CS, 8'h48);
    rssi(8'hff, 1'b0);
    // relative steps, absolute criterion off; baseline follows quiet samples
    for (int r = 0; r < 4; r++) begin
      wr(OFS_CS, {2'b01, 2'(r), 4'h8});
      rssi(8'h32, 1'b0);
      if (r == 0) begin
        rssi(8'hff, 1'b0);
      end else begin
        rssi(8'h31 + rs[r], 1'b0);
        rssi(8'h31 + rs[r] + rs[r], 1'b1);
        rssi(8'h32, 1'b0);
      end
    end
    // gain loop: discard length per wait code
    wr(OFS_GOAL, 8'h03);
    wr(OFS_CS, 8'h40);
    for (int w = 0; w < 4; w++) begin
      wr(OFS_TIMING, {2'b00, 2'(w), 4'h0});
      episode((w + 1) * 8 + 7, 8'h3c, 0);
      feed(1, 8'h3c);
      model_step(1);
      chk_gains();
    end
    // dead zone edge for each code, goal 33 dB
    for (int z = 0; z < 4; z++) begin
      wr(OFS_TIMING, {2'(z), 6'h00});
      episode(16, 8'd33 + up[z], 0);
      episode(16, 8'd34 + up[z], 1);
    end
    wr(OFS_CS, 8'h00);
    prio = 1'b0;
    wr(OFS_TIMING, 8'h00);
    repeat (2) episode(16, 8'h3c, 1);
    // lower dead zone edge, raise path
    for (int z = 0; z < 4; z++) begin
      wr(OFS_TIMING, {2'(z), 6'h00});
      episode(16, 8'd33 - lw[z], 0);
      episode(16, 8'd32 - lw[z], 3);
    end
    // hold on sync, then released by a new reception
    wr(OFS_TIMING, 8'h04);
    restart();
    sync_found = 1'b1;
    tick();
    sync_found = 1'b0;
    tick();
    feed(16, 8'h3c);
    chk_gains();
    episode(16, 8'h3c, 1);
    wr(OFS_TIMING, 8'h08);
    episode(16, 8'h3c, 2);
    // manual override, values must not drift
    man1 = 3'($random(seed));
    man2 = 3'($random(seed));
    mand = 3'($random(seed));
    e1 = man1;
    e2 = man2;
    ed = mand;
    wr(OFS_TIMING, 8'h0c);
    tick(2);
    chk_gains();
    episode(16, 8'h3c, 0);
    tick(2);
    finish_test();
  end
endmodule
`default_nettype wire
